// File: pif3_map.vh
// register offsets, bit positions and reset values of the flag register block
`ifndef PIF3_MAP_VH
`define PIF3_MAP_VH
`define PIF3_ADDR_W          4
`define PIF3_FLAGS_OFS       4'h0
`define PIF3_MODES_OFS       4'h1
`define PIF3_FLAGS_RST       8'h00
`define PIF3_MODES_RST       8'h00
`define PIF3_BIT_SYNC_DONE   7
`define PIF3_BIT_SYNC_COLL   6
`define PIF3_BIT_RX_FULL     5
`define PIF3_BIT_TX_EMPTY    4
`define PIF3_BIT_TMR_MATCH   3
`define PIF3_BIT_CC_E        2
`define PIF3_BIT_CC_D        1
`define PIF3_BIT_CC_C        0
`define PIF3_MODE_CAPTURE    2'h0
`define PIF3_MODE_COMPARE    2'h1
`define PIF3_MODE_PWM        2'h2
`endif

// File: pif3_ccflag.v
// sticky flag of one capture/compare unit, gated by that unit's mode
`timescale 1ns/1ps
`include "pif3_map.vh"
module pif3_ccflag (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire [1:0] mode,
    input  wire       capture_evt,
    input  wire       compare_evt,
    input  wire       sw_clear,
    output reg        flag_r
);
    reg flag_nxt;

    always @* begin
        flag_nxt = flag_r;
        if (sw_clear) begin
            flag_nxt = 1'b0;
        end
        // set wins over a clear in the same cycle; pwm mode never sets
        if (mode == `PIF3_MODE_CAPTURE && capture_evt) begin
            flag_nxt = 1'b1;
        end else if (mode == `PIF3_MODE_COMPARE && compare_evt) begin
            flag_nxt = 1'b1;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule // pif3_ccflag

// File: pif3_flags.v
// peripheral interrupt request flag register 3 with register port
`timescale 1ns/1ps
`include "pif3_map.vh"
// Behaviour
// - sync port b collision sets sticky flag; only software writing zero clears it
// - tx empty flag follows buffer empty status; read-only, cleared by buffer write
// - timer d count equal to period sets sticky flag until software clears it
// - capture mode: capture event sets unit flag until software clears it
// - compare mode: match sets unit flag, software clears; pwm mode leaves it unused
module pif3_flags #(
    parameter TIMER_W = 8
) (
    input  wire                   mclk,
    input  wire                   rst_n,
    input  wire [`PIF3_ADDR_W-1:0] addr,
    input  wire [7:0]             wdata,
    input  wire                   wr_stb,
    input  wire                   rd_stb,
    output reg  [7:0]             rdata,
    input  wire                   sync_done_evt,
    input  wire                   sync_coll_evt,
    input  wire                   rx_buf_full,
    input  wire                   tx_buf_empty,
    input  wire [TIMER_W-1:0]     timer_d_count,
    input  wire [TIMER_W-1:0]     timer_d_period,
    input  wire [2:0]             capture_evt,
    input  wire [2:0]             compare_evt,
    output wire [7:0]             irq_flags,
    output wire [5:0]             cc_mode
);

    // unit count is fixed by the layout: three mode fields of two bits each
    localparam STICKY_N = 3;
    localparam STATUS_N = 2;
    localparam CC_N     = 3;
    localparam [7:0] FLAGS_RST = `PIF3_FLAGS_RST;
    localparam [7:0] MODES_RST = `PIF3_MODES_RST;
    // reset values per group, in the bit order of the vectors below
    localparam [STICKY_N-1:0] STICKY_RST = {FLAGS_RST[`PIF3_BIT_SYNC_DONE],
                                            FLAGS_RST[`PIF3_BIT_SYNC_COLL],
                                            FLAGS_RST[`PIF3_BIT_TMR_MATCH]};
    localparam [STATUS_N-1:0] STATUS_RST = {FLAGS_RST[`PIF3_BIT_RX_FULL],
                                            FLAGS_RST[`PIF3_BIT_TX_EMPTY]};

    reg  [7:0]          flags_word;
    reg  [7:0]          rdata_nxt;
    reg                 match_seen_r;
    wire [STICKY_N-1:0] sticky_set;
    wire [STICKY_N-1:0] sticky_keep;
    wire [STICKY_N-1:0] sticky_q;
    wire [STATUS_N-1:0] status_in;
    wire [STATUS_N-1:0] status_q;
    wire [2*CC_N-1:0]   modes_q;
    wire [CC_N-1:0]     cc_clear;
    wire [CC_N-1:0]     cc_flag;
    wire                flags_wr;
    wire                modes_wr;
    wire                match_now;
    wire                match_evt;

    genvar gi;

    // true when the bus address selects the register at the given offset
    function addr_hit;
        input [`PIF3_ADDR_W-1:0] a;
        input [`PIF3_ADDR_W-1:0] ofs;
        begin
            addr_hit = (a == ofs);
        end
    endfunction

    // word returned by a read; unmapped offsets read as zero
    function [7:0] read_word;
        input [`PIF3_ADDR_W-1:0] a;
        input [7:0]              flags;
        input [2*CC_N-1:0]       modes;
        begin
            if (addr_hit(a, `PIF3_FLAGS_OFS)) begin
                read_word = flags;
            end else if (addr_hit(a, `PIF3_MODES_OFS)) begin
                read_word = {2'h0, modes};
            end else begin
                read_word = 8'h00;
            end
        end
    endfunction

    // writes to unmapped offsets match neither decode and are dropped
    assign flags_wr = wr_stb && addr_hit(addr, `PIF3_FLAGS_OFS);
    assign modes_wr = wr_stb && addr_hit(addr, `PIF3_MODES_OFS);

    // a count that sits on the period sets the flag only once, so a flag
    // cleared by software stays clear until the count leaves and returns
    assign match_now = (timer_d_count == timer_d_period);
    assign match_evt = match_now && !match_seen_r;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            match_seen_r <= 1'b0;
        end else begin
            match_seen_r <= match_now;
        end
    end

    // sticky flags, bit order: transfer done, collision, timer match
    assign sticky_set  = {sync_done_evt,
                          sync_coll_evt,
                          match_evt};
    // a written zero clears a sticky flag, a written one leaves it alone
    assign sticky_keep = {wdata[`PIF3_BIT_SYNC_DONE],
                          wdata[`PIF3_BIT_SYNC_COLL],
                          wdata[`PIF3_BIT_TMR_MATCH]};

    generate
        for (gi = 0; gi < STICKY_N; gi = gi + 1) begin : g_sticky
            reg flag_r;
            reg flag_nxt;

            // an event in the cycle of a clear wins, so no event is lost
            always @* begin
                flag_nxt = flag_r;
                if (flags_wr && !sticky_keep[gi]) begin
                    flag_nxt = 1'b0;
                end
                if (sticky_set[gi]) begin
                    flag_nxt = 1'b1;
                end
            end

            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_r <= STICKY_RST[gi];
                end else begin
                    flag_r <= flag_nxt;
                end
            end

            assign sticky_q[gi] = flag_r;
        end
    endgenerate

    // buffer status bits, order: rx full, tx empty; the port cannot write them
    assign status_in = {rx_buf_full, tx_buf_empty};

    generate
        for (gi = 0; gi < STATUS_N; gi = gi + 1) begin : g_status
            reg level_r;

            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    level_r <= STATUS_RST[gi];
                end else begin
                    level_r <= status_in[gi];
                end
            end

            assign status_q[gi] = level_r;
        end
    endgenerate

    // a written zero on a unit's bit clears that unit's flag
    assign cc_clear = {CC_N{flags_wr}} & ~{wdata[`PIF3_BIT_CC_E],
                                           wdata[`PIF3_BIT_CC_D],
                                           wdata[`PIF3_BIT_CC_C]};

    // one mode field and one flag per unit, order c, d, e;
    // modes 2 and 3 make the unit ignore both of its events
    generate
        for (gi = 0; gi < CC_N; gi = gi + 1) begin : g_cc
            reg [1:0] mode_r;

            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mode_r <= MODES_RST[2*gi+1:2*gi];
                end else if (modes_wr) begin
                    mode_r <= wdata[2*gi+1:2*gi];
                end
            end

            assign modes_q[2*gi+1:2*gi] = mode_r;

            pif3_ccflag u_cc (
                .mclk        (mclk),
                .rst_n       (rst_n),
                .mode        (mode_r),
                .capture_evt (capture_evt[gi]),
                .compare_evt (compare_evt[gi]),
                .sw_clear    (cc_clear[gi]),
                .flag_r      (cc_flag[gi])
            );
        end
    endgenerate

    // flag register word, each bit at its mapped position
    always @* begin
        flags_word                      = 8'h00;
        flags_word[`PIF3_BIT_SYNC_DONE] = sticky_q[2];
        flags_word[`PIF3_BIT_SYNC_COLL] = sticky_q[1];
        flags_word[`PIF3_BIT_RX_FULL]   = status_q[1];
        flags_word[`PIF3_BIT_TX_EMPTY]  = status_q[0];
        flags_word[`PIF3_BIT_TMR_MATCH] = sticky_q[0];
        flags_word[`PIF3_BIT_CC_E]      = cc_flag[2];
        flags_word[`PIF3_BIT_CC_D]      = cc_flag[1];
        flags_word[`PIF3_BIT_CC_C]      = cc_flag[0];
    end

    assign irq_flags = flags_word;
    assign cc_mode   = modes_q;

    // read data stands only in the cycle after the strobe, zero otherwise
    always @* begin
        rdata_nxt = 8'h00;
        if (rd_stb) begin
            rdata_nxt = read_word(addr, flags_word, modes_q);
        end
    end

    // the read mux is registered so rdata comes straight from flip-flops
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule // pif3_flags

// File: pif3_checker.sv
// port assertions for the flag register block
`timescale 1ns/1ps
module pif3_checker #(
    parameter TIMER_W = 8
) (
    input wire               mclk,
    input wire               rst_n,
    input wire               wr_stb,
    input wire               sync_coll_evt,
    input wire               rx_buf_full,
    input wire               tx_buf_empty,
    input wire [3:0]         addr,
    input wire [7:0]         wdata,
    input wire [7:0]         irq_flags,
    input wire [TIMER_W-1:0] timer_d_count,
    input wire [TIMER_W-1:0] timer_d_period,
    input wire [2:0]         capture_evt,
    input wire [2:0]         compare_evt,
    input wire [5:0]         cc_mode
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire clr = wr_stb && addr == 4'h0;
    a_coll_sets: assert property (sync_coll_evt |=> irq_flags[6])
        else $error("collision flag not set");
    a_coll_clears: assert property (clr && !wdata[6] && !sync_coll_evt |=> !irq_flags[6])
        else $error("collision flag not cleared");
    a_tx_follows: assert property ($past(rst_n) |-> irq_flags[4] == $past(tx_buf_empty))
        else $error("tx flag wrong");
    a_rx_follows: assert property ($past(rst_n) |-> irq_flags[5] == $past(rx_buf_full))
        else $error("rx flag wrong");
    a_match_sets: assert property ($rose(timer_d_count == timer_d_period) |=> irq_flags[3])
        else $error("match flag not set");
    a_capture_sets: assert property (capture_evt[2] && cc_mode[5:4] == 2'h0 |=> irq_flags[2])
        else $error("capture flag not set");
    a_compare_sets: assert property (compare_evt[0] && cc_mode[1:0] == 2'h1 |=> irq_flags[0])
        else $error("compare flag not set");
    a_match_clears: assert property (clr && !wdata[3] &&
        !$rose(timer_d_count == timer_d_period) |=> !irq_flags[3])
        else $error("match flag not cleared");
    a_pwm_no_set: assert property (cc_mode[3:2] == 2'h2 &&
        !irq_flags[1] |=> !irq_flags[1])
        else $error("pwm mode set a flag");
endmodule // pif3_checker
bind pif3_flags pif3_checker #(.TIMER_W(TIMER_W)) pif3_checker_i (.*);

// File: pif3_periph.sv
// far-side model: timer d counter and async port b buffer status
`timescale 1ns/1ps
module pif3_periph (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       rx_in,
    input  wire       tx_wr,
    output reg  [7:0] timer_d_count,
    output reg        rx_buf_full,
    output reg        tx_buf_empty
);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_d_count <= 8'h00;
            rx_buf_full   <= 1'b0;
            tx_buf_empty  <= 1'b1;
        end else begin
            timer_d_count <= timer_d_count == 8'h05 ? 8'h00 : timer_d_count + 8'h01;
            rx_buf_full   <= rx_in;
            tx_buf_empty  <= !tx_wr;
        end
    end
endmodule // pif3_periph

// File: testbench.sv
// random bench: flag register against a cycle model
`timescale 1ns/1ps
module testbench;
    reg         mclk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, rx_in = 0, tx_wr = 0, eq_d;
    reg         sync_done_evt = 0, sync_coll_evt = 0;
    reg  [3:0]  addr = 0;
    reg  [7:0]  wdata = 0, m, xr, s;
    reg  [2:0]  capture_evt = 0, compare_evt = 0;
    reg  [5:0]  md;
    reg  [31:0] x = 32'h16D932B3;
    wire [7:0]  rdata, irq_flags, timer_d_count, timer_d_period = 8'h05;
    wire [5:0]  cc_mode;
    wire        rx_buf_full, tx_buf_empty;
    integer     bad_count = 0, checks = 0, i;
    pif3_flags pif3_flags_i (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .addr           (addr),
        .wdata          (wdata),
        .wr_stb         (wr_stb),
        .rd_stb         (rd_stb),
        .rdata          (rdata),
        .sync_done_evt  (sync_done_evt),
        .sync_coll_evt  (sync_coll_evt),
        .rx_buf_full    (rx_buf_full),
        .tx_buf_empty   (tx_buf_empty),
        .timer_d_count  (timer_d_count),
        .timer_d_period (timer_d_period),
        .capture_evt    (capture_evt),
        .compare_evt    (compare_evt),
        .irq_flags      (irq_flags),
        .cc_mode        (cc_mode)
    );
    pif3_periph pif3_periph_i (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .rx_in         (rx_in),
        .tx_wr         (tx_wr),
        .timer_d_count (timer_d_count),
        .rx_buf_full   (rx_buf_full),
        .tx_buf_empty  (tx_buf_empty)
    );
    initial forever #10 mclk = ~mclk;
    function [31:0] xs(input [31:0] v);
        xs = v ^ v << 13;
        xs = xs ^ xs >> 17;
        xs = xs ^ xs << 5;
    endfunction
    task chk(input [7:0] got, exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0t %h %h", $time, got, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    always @(posedge mclk)
        if (!rst_n) {m, md, xr, eq_d} = 0;
        else begin
            xr = !rd_stb ? 8'h00 : addr == 4'h0 ? m : addr == 4'h1 ? {2'h0, md} : 8'h00;
            s = {sync_done_evt, sync_coll_evt, 2'h0, timer_d_count == 8'h05 && !eq_d, 3'h0};
            for (i = 0; i < 3; i = i + 1)
                s[i] = md[2*i+:2] == 2'h0 && capture_evt[i] || md[2*i+:2] == 2'h1 && compare_evt[i];
            m = (wr_stb && addr == 4'h0 ? m & wdata : m) | s;
            m[5:4] = {rx_buf_full, tx_buf_empty};
            if (wr_stb && addr == 4'h1) md = wdata[5:0];
            eq_d = timer_d_count == 8'h05;
        end
    always @(negedge mclk) begin
        chk(irq_flags, m);
        chk(rdata, xr);
        chk({2'h0, cc_mode}, {2'h0, md});
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        repeat (3000) begin
            @(posedge mclk);
            x = xs(x);
            {wr_stb, rd_stb, addr, wdata} <= {x[1:0] == 2'h1, x[1:0] == 2'h2, 2'h0, x[3:2], x[31:24]};
            {sync_done_evt, sync_coll_evt, rx_in, tx_wr} <= {&x[5:4], &x[7:6], x[20], &x[22:21]};
            {capture_evt, compare_evt} <= {x[10:8] & x[13:11], x[16:14] & x[19:17]};
        end
        tally_and_finish;
    end
endmodule // testbench
